/* core/ext_bus_consts.svh */
// Timing counts, widths and codes shared by the external bus sequencer.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH

`define EXT_BUS_ADDR_W        24
`define EXT_BUS_DATA_W        8
`define EXT_BUS_STATE_MIN     4'h2
`define EXT_BUS_STATE_MAX     4'hf
`define EXT_BUS_STATE_RST     4'h2
`define EXT_BUS_MODE_MUX      1'b0
`define EXT_BUS_MODE_STROBE   1'b1
`define EXT_BUS_SWITCH_CYCLES 4'h1

`endif

/* core/ext_bus_pkg.sv */
// Types shared by the external bus sequencer modules.
package ext_bus_pkg;

    // Bus phases of both modes, plus idle and the mode change gap.
    typedef enum logic [3:0] {
        PH_IDLE,
        PH_SWITCH,
        PH_T1,
        PH_T2,
        PH_T3,
        PH_TWAIT,
        PH_T4,
        PH_S0,
        PH_S1,
        PH_S2,
        PH_S3,
        PH_S4,
        PH_S4WAIT,
        PH_S5,
        PH_S6,
        PH_S7
    } phase_t;

endpackage

/* core/ext_bus_timer_if.sv */
// Interface joining the sequencer to its per-state timer.
`timescale 1ns/10ps
interface ext_bus_timer_if;
    logic       load;
    logic [3:0] length;
    logic       half;
    logic       last;

    modport ctrl  (output load, output length, input half, input last);
    modport timer (input load, input length, output half, output last);
endinterface

/* core/ext_bus_state_timer.sv */
// Counts the system clocks of one bus state and flags its middle and its end.
`timescale 1ns/10ps
`include "ext_bus_consts.svh"
module ext_bus_state_timer
(
    // Clock and control.
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_enable,
    // Sequencer side.
    ext_bus_timer_if.timer  tmr
);
    logic [3:0] count_q;
    logic [3:0] count_d;
    logic [3:0] len_q;
    logic [3:0] len_d;

    // Reload on request, otherwise count up to the loaded length.
    always_comb
    begin
        count_d = count_q;
        len_d   = len_q;
        if (tmr.load)
        begin
            count_d = 4'h1;
            len_d   = tmr.length;
        end
        else if (count_q < len_q)
        begin
            count_d = count_q + 4'h1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            count_q <= 4'h1;
            len_q   <= `EXT_BUS_STATE_RST;
        end
        else if (i_enable)
        begin
            count_q <= count_d;
            len_q   <= len_d;
        end
    end

    // Middle reached once the first half of the state has passed.
    assign tmr.half = (count_q >= (len_q >> 1));
    assign tmr.last = (count_q >= len_q);
endmodule

/* core/ext_bus_sync.sv */
// Two-flop synchroniser for the asynchronous wait and acknowledge pins.
`timescale 1ns/10ps
module ext_bus_sync
(
    // Clock and control.
    input  wire logic i_clock,
    input  wire logic i_sys_rst,
    input  wire logic i_enable,
    // Pin and result.
    input  wire logic i_pin,
    output logic      o_level
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // Both stages idle high, the inactive level of the pins.
    always_comb
    begin
        meta_d = i_pin;
        sync_d = meta_q;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end
        else if (i_enable)
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_level = sync_q;
endmodule

/* core/ext_bus_mode_sequencer.sv */
// External bus cycle sequencer: multiplexed latch-strobed and strobe-acknowledge modes.
// Behaviour
// - Mux read T1: address on data bus, chip select asserted.
// - Mux cycles: latch pulse high at T1 start, low at T1 middle.
// - Mux read T2: address off data bus, read strobe, memory or port request.
// - Mux write T2: write data replaces address, write strobe asserted.
// - Hold line low before T3 inserts frozen wait states until high.
// - Mux read: capture data at T4 start, negate read strobe, finish.
// - Mux write: negate write strobe at T4, hold buses until T4 ends.
// - Strobe mode runs every cycle through eight states S0 to S7.
// - Strobe read: direction line high in S0.
// - Strobe mode: 24-bit address valid on entering S1.
// - Strobe read: both strobes at S2; nothing changes in S3, S5.
// - Sample acknowledge in S4; add whole-state waits until asserted.
// - Strobe read: capture data and negate strobes entering S7.
// - Strobe write: direction line returned high in S0.
// - Strobe write: address strobe and direction low at S2.
// - Strobe write: data bus driven with write data in S3.
// - Strobe write: data strobe at S4; nothing changes in S5, S6.
// - Strobe write: strobes off entering S7, direction high ending S7.
// - One extra clock when consecutive accesses change mode.
// - Mux T1: low address byte on data bus and on address lines.
// - Each latch-strobed state lasts 2 to 15 system clocks.
`timescale 1ns/10ps
`include "ext_bus_consts.svh"
module ext_bus_mode_sequencer #(
    parameter int ADDR_W = `EXT_BUS_ADDR_W,
    parameter int DATA_W = `EXT_BUS_DATA_W
)
(
    // Clock, reset and enable.
    input  wire logic              i_clock,
    input  wire logic              i_sys_rst,
    input  wire logic              i_enable,
    // Access request from the core.
    input  wire logic              i_req_valid,
    output logic                   o_req_ready,
    input  wire logic              i_req_write,
    input  wire logic              i_req_port,
    input  wire logic              i_req_mode,
    input  wire logic [3:0]        i_req_state_len,
    input  wire logic [ADDR_W-1:0] i_req_addr,
    input  wire logic [DATA_W-1:0] i_req_wdata,
    // Access completion.
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata,
    // Bus pins.
    output logic [ADDR_W-1:0]      o_addr,
    input  wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0]      o_data,
    output logic                   o_data_oe,
    output logic                   o_chip_select_n,
    output logic                   o_addr_latch,
    output logic                   o_read_n,
    output logic                   o_write_n,
    output logic                   o_memory_request_n,
    output logic                   o_port_request_n,
    output logic                   o_read_not_write,
    output logic                   o_address_strobe_n,
    output logic                   o_data_strobe_n,
    input  wire logic              i_hold_n,
    input  wire logic              i_transfer_acknowledge_n
);
    ext_bus_timer_if tmr ();

    logic hold_n_s;
    logic ack_n_s;

    // Sequencer state.
    ext_bus_pkg::phase_t phase_q;
    ext_bus_pkg::phase_t phase_d;
    logic                mode_q;
    logic                mode_d;
    logic                wr_q;
    logic                wr_d;
    logic                port_q;
    logic                port_d;
    logic [3:0]          len_q;
    logic [3:0]          len_d;
    logic [ADDR_W-1:0]   addr_q;
    logic [ADDR_W-1:0]   addr_d;
    logic [DATA_W-1:0]   wdata_q;
    logic [DATA_W-1:0]   wdata_d;
    logic [DATA_W-1:0]   rdata_q;
    logic [DATA_W-1:0]   rdata_d;
    logic                done_q;
    logic                done_d;
    logic                pend_q;
    logic                pend_d;

    // Bus pin registers.
    logic [DATA_W-1:0]   dout_q;
    logic [DATA_W-1:0]   dout_d;
    logic                doe_q;
    logic                doe_d;
    logic                cs_n_q;
    logic                cs_n_d;
    logic                ale_q;
    logic                ale_d;
    logic                rd_n_q;
    logic                rd_n_d;
    logic                wr_n_q;
    logic                wr_n_d;
    logic                mrq_n_q;
    logic                mrq_n_d;
    logic                preq_n_q;
    logic                preq_n_d;
    logic                rnw_q;
    logic                rnw_d;
    logic                asb_n_q;
    logic                asb_n_d;
    logic                dsb_n_q;
    logic                dsb_n_d;

    // Clamp a requested state length into the legal 2..15 range.
    function automatic logic [3:0] clamp_len(input logic [3:0] len);
        clamp_len = (len < `EXT_BUS_STATE_MIN) ? `EXT_BUS_STATE_MIN : len;
    endfunction

    // Asynchronous pins pass two flops before any logic looks at them.
    ext_bus_sync u_hold_sync (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_enable  (i_enable),
        .i_pin     (i_hold_n),
        .o_level   (hold_n_s)
    );

    ext_bus_sync u_ack_sync (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_enable  (i_enable),
        .i_pin     (i_transfer_acknowledge_n),
        .o_level   (ack_n_s)
    );

    ext_bus_state_timer u_timer (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_enable  (i_enable),
        .tmr       (tmr)
    );

    // A new access is taken only while idle.
    assign o_req_ready = (phase_q == ext_bus_pkg::PH_IDLE);

    // Next phase and pin values; each state lasts one timer period.
    always_comb
    begin
        phase_d    = phase_q;
        mode_d     = mode_q;
        wr_d       = wr_q;
        port_d     = port_q;
        len_d      = len_q;
        addr_d     = addr_q;
        wdata_d    = wdata_q;
        rdata_d    = rdata_q;
        done_d     = 1'b0;
        pend_d     = pend_q;
        dout_d     = dout_q;
        doe_d      = doe_q;
        cs_n_d     = cs_n_q;
        ale_d      = ale_q;
        rd_n_d     = rd_n_q;
        wr_n_d     = wr_n_q;
        mrq_n_d    = mrq_n_q;
        preq_n_d   = preq_n_q;
        rnw_d      = rnw_q;
        asb_n_d    = asb_n_q;
        dsb_n_d    = dsb_n_q;
        tmr.load   = 1'b0;
        tmr.length = len_q;
        case (phase_q)
            ext_bus_pkg::PH_IDLE:
            begin
                if (i_req_valid)
                begin
                    wr_d    = i_req_write;
                    port_d  = i_req_port;
                    len_d   = clamp_len(i_req_state_len);
                    addr_d  = i_req_addr;
                    wdata_d = i_req_wdata;
                    mode_d  = i_req_mode;
                    tmr.load   = 1'b1;
                    tmr.length = clamp_len(i_req_state_len);
                    if (pend_q && (i_req_mode != mode_q))
                    begin
                        tmr.length = `EXT_BUS_SWITCH_CYCLES;
                        phase_d    = ext_bus_pkg::PH_SWITCH;
                    end
                    else if (i_req_mode == `EXT_BUS_MODE_MUX)
                    begin
                        phase_d = ext_bus_pkg::PH_T1;
                        cs_n_d  = 1'b0;
                        ale_d   = 1'b1;
                        dout_d  = i_req_addr[DATA_W-1:0];
                        doe_d   = 1'b1;
                    end
                    else
                    begin
                        phase_d = ext_bus_pkg::PH_S0;
                        cs_n_d  = 1'b0;
                        rnw_d   = 1'b1;
                    end
                    pend_d = 1'b1;
                end
            end
            ext_bus_pkg::PH_SWITCH:
            begin
                // The single gap clock is over; start the access proper.
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    cs_n_d   = 1'b0;
                    if (mode_q == `EXT_BUS_MODE_MUX)
                    begin
                        phase_d = ext_bus_pkg::PH_T1;
                        ale_d   = 1'b1;
                        dout_d  = addr_q[DATA_W-1:0];
                        doe_d   = 1'b1;
                    end
                    else
                    begin
                        phase_d = ext_bus_pkg::PH_S0;
                        rnw_d   = 1'b1;
                    end
                end
            end
            ext_bus_pkg::PH_T1:
            begin
                if (tmr.half)
                    ale_d = 1'b0;
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ext_bus_pkg::PH_T2;
                    ale_d    = 1'b0;
                    mrq_n_d  = port_q;
                    preq_n_d = ~port_q;
                    if (wr_q)
                    begin
                        dout_d = wdata_q;
                        wr_n_d = 1'b0;
                    end
                    else
                    begin
                        doe_d  = 1'b0;
                        rd_n_d = 1'b0;
                    end
                end
            end
            ext_bus_pkg::PH_T2:
            begin
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = hold_n_s ? ext_bus_pkg::PH_T3 : ext_bus_pkg::PH_TWAIT;
                end
            end
            ext_bus_pkg::PH_TWAIT:
            begin
                // Bus frozen; stay a whole state per wait until the hold releases.
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    if (hold_n_s)
                        phase_d = ext_bus_pkg::PH_T3;
                end
            end
            ext_bus_pkg::PH_T3:
            begin
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ext_bus_pkg::PH_T4;
                    if (!wr_q)
                        rdata_d = i_data;
                    rd_n_d = 1'b1;
                    wr_n_d = 1'b1;
                end
            end
            ext_bus_pkg::PH_T4:
            begin
                // Address and data held until the very end of T4.
                if (tmr.last)
                begin
                    phase_d  = ext_bus_pkg::PH_IDLE;
                    done_d   = 1'b1;
                    doe_d    = 1'b0;
                    cs_n_d   = 1'b1;
                    mrq_n_d  = 1'b1;
                    preq_n_d = 1'b1;
                end
            end
            ext_bus_pkg::PH_S0:
            begin
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ext_bus_pkg::PH_S1;
                end
            end
            ext_bus_pkg::PH_S1:
            begin
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ext_bus_pkg::PH_S2;
                    asb_n_d  = 1'b0;
                    if (wr_q)
                        rnw_d = 1'b0;
                    else
                        dsb_n_d = 1'b0;
                end
            end
            ext_bus_pkg::PH_S2:
            begin
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ext_bus_pkg::PH_S3;
                    if (wr_q)
                    begin
                        dout_d = wdata_q;
                        doe_d  = 1'b1;
                    end
                end
            end
            ext_bus_pkg::PH_S3:
            begin
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ext_bus_pkg::PH_S4;
                    if (wr_q)
                        dsb_n_d = 1'b0;
                end
            end
            ext_bus_pkg::PH_S4, ext_bus_pkg::PH_S4WAIT:
            begin
                // The synchronised acknowledge already lags the pin by a clock or more.
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ack_n_s ? ext_bus_pkg::PH_S4WAIT : ext_bus_pkg::PH_S5;
                end
            end
            ext_bus_pkg::PH_S5:
            begin
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ext_bus_pkg::PH_S6;
                end
            end
            ext_bus_pkg::PH_S6:
            begin
                if (tmr.last)
                begin
                    tmr.load = 1'b1;
                    phase_d  = ext_bus_pkg::PH_S7;
                    if (!wr_q)
                        rdata_d = i_data;
                    asb_n_d = 1'b1;
                    dsb_n_d = 1'b1;
                end
            end
            ext_bus_pkg::PH_S7:
            begin
                if (tmr.last)
                begin
                    phase_d = ext_bus_pkg::PH_IDLE;
                    done_d  = 1'b1;
                    rnw_d   = 1'b1;
                    doe_d   = 1'b0;
                    cs_n_d  = 1'b1;
                end
            end
            default:
            begin
                phase_d = ext_bus_pkg::PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            phase_q  <= ext_bus_pkg::PH_IDLE;
            mode_q   <= `EXT_BUS_MODE_MUX;
            wr_q     <= 1'b0;
            port_q   <= 1'b0;
            len_q    <= `EXT_BUS_STATE_RST;
            addr_q   <= '0;
            wdata_q  <= '0;
            rdata_q  <= '0;
            done_q   <= 1'b0;
            pend_q   <= 1'b0;
            dout_q   <= '0;
            doe_q    <= 1'b0;
            cs_n_q   <= 1'b1;
            ale_q    <= 1'b0;
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
            mrq_n_q  <= 1'b1;
            preq_n_q <= 1'b1;
            rnw_q    <= 1'b1;
            asb_n_q  <= 1'b1;
            dsb_n_q  <= 1'b1;
        end
        else if (i_enable)
        begin
            phase_q  <= phase_d;
            mode_q   <= mode_d;
            wr_q     <= wr_d;
            port_q   <= port_d;
            len_q    <= len_d;
            addr_q   <= addr_d;
            wdata_q  <= wdata_d;
            rdata_q  <= rdata_d;
            done_q   <= done_d;
            pend_q   <= pend_d;
            dout_q   <= dout_d;
            doe_q    <= doe_d;
            cs_n_q   <= cs_n_d;
            ale_q    <= ale_d;
            rd_n_q   <= rd_n_d;
            wr_n_q   <= wr_n_d;
            mrq_n_q  <= mrq_n_d;
            preq_n_q <= preq_n_d;
            rnw_q    <= rnw_d;
            asb_n_q  <= asb_n_d;
            dsb_n_q  <= dsb_n_d;
        end
    end

    // Registered pins; the address bus holds the latched access address.
    assign o_addr             = addr_q;
    assign o_data             = dout_q;
    assign o_data_oe          = doe_q;
    assign o_chip_select_n    = cs_n_q;
    assign o_addr_latch       = ale_q;
    assign o_read_n           = rd_n_q;
    assign o_write_n          = wr_n_q;
    assign o_memory_request_n = mrq_n_q;
    assign o_port_request_n   = preq_n_q;
    assign o_read_not_write   = rnw_q;
    assign o_address_strobe_n = asb_n_q;
    assign o_data_strobe_n    = dsb_n_q;
    assign o_done             = done_q;
    assign o_rdata            = rdata_q;
endmodule

/* verif/ext_bus_periph_model.sv */
// Peripheral model on the far side of the bus.
`timescale 1ns/10ps
module ext_bus_periph_model
(
    // Bus pins from the sequencer.
    input  wire logic       i_clock,
    input  wire logic       i_cs_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_asb_n,
    input  wire logic       i_dsb_n,
    input  wire logic       i_rnw,
    // Settings from the bench.
    input  wire logic [4:0] i_delay,
    input  wire logic [7:0] i_rdata,
    // Responses.
    output logic [7:0]      o_data,
    output logic            o_hold_n,
    output logic            o_ack_n
);
    logic [4:0] cnt_q = 5'h00;
    logic [7:0] last_q = 8'h00;
    // Counts clocks of a selected cycle and keeps the last byte seen.
    always_ff @(posedge i_clock)
    begin
        cnt_q  <= i_cs_n ? 5'h00 : cnt_q + {4'h0, cnt_q != 5'h1f};
        last_q <= o_data;
    end
    // Read data under a read strobe; a changing pattern otherwise.
    assign o_data = (i_rnw && (!i_rd_n || !i_dsb_n)) ? i_rdata : ~last_q;
    // Wait held low for the first delay clocks of a cycle.
    assign o_hold_n = i_cs_n || (cnt_q >= i_delay);
    // Acknowledge after the delay, dropped once the strobes release.
    assign o_ack_n = i_asb_n || (cnt_q < i_delay);
endmodule

/* verif/ext_bus_mode_sequencer_chk.sv */
// Pin relation checks for the external bus sequencer.
`timescale 1ns/10ps
module ext_bus_mode_sequencer_chk
(
    // Watched ports.
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic        o_req_ready,
    input wire logic        o_done,
    input wire logic [23:0] o_addr,
    input wire logic [7:0]  o_data,
    input wire logic        o_data_oe,
    input wire logic        o_chip_select_n,
    input wire logic        o_addr_latch,
    input wire logic        o_read_n,
    input wire logic        o_write_n,
    input wire logic        o_memory_request_n,
    input wire logic        o_port_request_n,
    input wire logic        o_read_not_write,
    input wire logic        o_address_strobe_n,
    input wire logic        o_data_strobe_n
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // Latch pulse framing the low address byte; mux read and write strobes.
    a_ale_addr: assert property ($rose(o_addr_latch) |-> !o_chip_select_n && o_data_oe && o_data == o_addr[7:0])
        else $error("latch pulse without address");
    a_ale_drop: assert property ($rose(o_addr_latch) |=> ##[0:7] !o_addr_latch)
        else $error("latch pulse too long");
    a_read_req: assert property ($fell(o_read_n) |-> !o_data_oe && !$past(o_addr_latch)
        && (o_memory_request_n ^ o_port_request_n))
        else $error("read strobe without single request");
    a_write_drv: assert property ($fell(o_write_n) |-> o_data_oe && !o_chip_select_n)
        else $error("write strobe without data drive");
    // Strobe mode edges and the idle bus at done.
    a_both_strobes: assert property ($fell(o_address_strobe_n) && o_read_not_write |-> $fell(o_data_strobe_n))
        else $error("read strobes apart");
    a_write_dir: assert property ($fell(o_address_strobe_n) && o_data_strobe_n |-> !o_read_not_write ##[1:15] o_data_oe)
        else $error("write direction or drive missing");
    a_dstb_drive: assert property ($fell(o_data_strobe_n) && !o_read_not_write |-> o_data_oe)
        else $error("write data strobe without data");
    a_strobes_off: assert property ($rose(o_address_strobe_n) |-> $rose(o_data_strobe_n) && !o_chip_select_n)
        else $error("strobes released apart");
    a_done_idle: assert property (o_done |-> o_req_ready && o_chip_select_n && o_read_n && o_write_n && o_read_not_write && !o_data_oe)
        else $error("bus not idle at done");
    // Main scenarios.
    c_mux_read: cover property ($fell(o_read_n));
    c_strobe_write: cover property ($fell(o_data_strobe_n) && !o_read_not_write);
    c_done: cover property (o_done);
endmodule
bind ext_bus_mode_sequencer ext_bus_mode_sequencer_chk u_chk (
    .i_clock, .i_sys_rst, .o_req_ready, .o_done, .o_addr, .o_data, .o_data_oe, .o_chip_select_n, .o_addr_latch,
    .o_read_n, .o_write_n, .o_memory_request_n, .o_port_request_n, .o_read_not_write, .o_address_strobe_n,
    .o_data_strobe_n
);

/* verif/ext_bus_mode_sequencer_tb_top.sv */
// Self-checking bench for the external bus sequencer.
`timescale 1ns/10ps
module ext_bus_mode_sequencer_tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        valid = 1'b0;
    logic        wr = 1'b0;
    logic        port = 1'b0;
    logic        mode = 1'b0;
    logic [3:0]  len = 4'h2;
    logic [4:0]  dly = 5'h00;
    logic [23:0] addr = 24'h000000;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  pdat = 8'h00;
    logic [23:0] a;
    logic [7:0]  rdata, din, d, ws;
    logic        ready, done, oe, cs_n, ale, rd_n, wr_n, mrq_n, port_n, rnw, asb_n, dsb_n, hold_n, ack_n, ps;
    logic        last_m = 1'b0;
    logic        first = 1'b1;
    int          failures = 0;
    int          n_checks = 0;
    int          x;
    // Design and far-side model.
    ext_bus_mode_sequencer u_dut (
        .i_clock(clock), .i_sys_rst(rst), .i_enable(1'b1), .i_req_valid(valid), .o_req_ready(ready),
        .i_req_write(wr), .i_req_port(port), .i_req_mode(mode), .i_req_state_len(len),
        .i_req_addr(addr), .i_req_wdata(wdata), .o_done(done), .o_rdata(rdata), .o_addr(a),
        .i_data(din), .o_data(d), .o_data_oe(oe), .o_chip_select_n(cs_n), .o_addr_latch(ale),
        .o_read_n(rd_n), .o_write_n(wr_n), .o_memory_request_n(mrq_n), .o_port_request_n(port_n),
        .o_read_not_write(rnw), .o_address_strobe_n(asb_n), .o_data_strobe_n(dsb_n),
        .i_hold_n(hold_n), .i_transfer_acknowledge_n(ack_n));
    ext_bus_periph_model u_periph (
        .i_clock(clock), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_asb_n(asb_n), .i_dsb_n(dsb_n), .i_rnw(rnw),
        .i_delay(dly), .i_rdata(pdat), .o_data(din), .o_hold_n(hold_n), .o_ack_n(ack_n));
    // Clock at 5 ns period.
    always #2.5 clock = ~clock;
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Compares one value and counts the outcome.
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        begin
            n_checks++;
            if (got !== exp)
            begin
                failures++;
                $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Runs one access; returns clocks beyond the plain length, port flag and written byte.
    task automatic acc(input logic m, input logic w, input logic p, input logic [3:0] l, input logic [4:0] dl,
                       input logic [23:0] ad);
        int n;
        begin
            n = 0;
            ps = 1'b0;
            ws = 8'h00;
            @(posedge clock);
            {mode, wr, port, len, dly, addr} <= {m, w, p, l, dl, ad};
            wdata <= ~ad[7:0];
            pdat <= ad[15:8];
            valid <= 1'b1;
            @(posedge clock);
            valid <= 1'b0;
            while (done !== 1'b1 && n < 400)
            begin
                @(posedge clock);
                #1;
                n++;
                if (port_n === 1'b0) ps = 1'b1;
                if (wr_n === 1'b0 || (dsb_n === 1'b0 && rnw === 1'b0)) ws = d;
            end
            x = n - (m ? 8 : 4) * ((l < 4'h2) ? 2 : int'(l)) - ((first || m == last_m) ? 0 : 1);
            first = 1'b0;
            last_m = m;
        end
    endtask
    // Multiplexed cycles at short, odd, longest and clamped lengths.
    task automatic t_mux;
        begin
            acc(1'b0, 1'b0, 1'b0, 4'h2, 5'h00, 24'h12a5c3);
            chk(24'(x), 24'h0);
            chk({23'h0, ps}, 24'h0);
            chk({16'h0, rdata}, 24'h0000a5);
            acc(1'b0, 1'b1, 1'b1, 4'h3, 5'h00, 24'h00345a);
            chk(24'(x), 24'h0);
            chk({23'h0, ps}, 24'h1);
            chk({16'h0, ws}, 24'h0000a5);
            acc(1'b0, 1'b0, 1'b1, 4'hf, 5'h00, 24'h800001);
            chk(24'(x), 24'h0);
            acc(1'b0, 1'b0, 1'b0, 4'h0, 5'h00, 24'h000002);
            chk(24'(x), 24'h0);
        end
    endtask
    // Strobe mode read then write, entered from the other mode.
    task automatic t_strobe;
        begin
            acc(1'b1, 1'b0, 1'b0, 4'h2, 5'h00, 24'habcdef);
            chk(24'(x), 24'h0);
            chk(a, 24'habcdef);
            chk({16'h0, rdata}, 24'h0000cd);
            acc(1'b1, 1'b1, 1'b0, 4'h2, 5'h00, 24'h654321);
            chk(24'(x), 24'h0);
            chk({16'h0, ws}, 24'h0000de);
        end
    endtask
    // Slow peripheral: hold and late acknowledge add whole states.
    task automatic t_wait;
        begin
            acc(1'b0, 1'b0, 1'b0, 4'h2, 5'h14, 24'h117711);
            chk(24'(x > 0 && x % 2 == 0), 24'h1);
            chk({16'h0, rdata}, 24'h000077);
            acc(1'b1, 1'b1, 1'b0, 4'h3, 5'h1f, 24'h222222);
            chk(24'(x > 0 && x % 3 == 0), 24'h1);
        end
    endtask
    // Reset, then the scenarios.
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_mux();
        t_strobe();
        t_wait();
        report_and_stop();
    end
    // Watchdog against a hang.
    initial
    begin
        #20000;
        failures++;
        report_and_stop();
    end
endmodule
